//--- core/ispm_pkg.sv
// package for the idle/stop power-mode controller
// assumes a single 40 MHz system clock and an AHB-Lite register port
package ispm_pkg;
  localparam logic [11:0] ADDR_PWR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_WAKE_CFG = 12'h008;
  localparam int BIT_IDLE = 0;
  localparam int BIT_STOP = 1;
  localparam int BIT_GP_LO = 2;
  localparam int BIT_GP_HI = 7;
  localparam int BIT_WAKE_MASK = 0;
  localparam logic [31:0] RST_PWR_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_WAKE_CFG = 32'h0000_0000;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam int RST_HOLD_CYCLES = 4;
  localparam int RST_CNT_W = 3;

  typedef enum logic [1:0]
  {
    ISPM_RUN = 2'b00,
    ISPM_IDLE = 2'b01,
    ISPM_STOP = 2'b11,
    ISPM_RESET = 2'b10
  } ispm_state_t;

  typedef struct packed
  {
    logic wdt_reset;
    logic mcd_reset;
    logic ext_reset;
  } ispm_rst_src_t;

  typedef struct packed
  {
    logic cpu_halt;
    logic hfosc_halt;
    logic cpu_reset;
  } ispm_ctrl_t;
endpackage

//--- core/ispm_sync.sv
// two-flop synchroniser bank for asynchronous inputs
// assumes the destination clock is the system clock
`timescale 1ns/1ps
module ispm_sync #(
  parameter int W = 1
) (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, low
  input wire logic [W-1:0] d, // async inputs
  output logic [W-1:0] q // synchronised outputs
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

//--- core/ispm_top.sv
// idle and stop mode control: halts the cpu core and precision oscillator
// assumes the core asserts INSN_DONE when the current instruction retires,
// and that reset sources arrive asynchronously from the reset system
// How it works
// [RL1] idle bit halts cpu after writing instruction
// [RL2] idle freezes only cpu, state preserved
// [RL3] peripheral clocks never gated by idle
// [RL4] idle ends on enabled interrupt or reset
// [RL5] enabled interrupt clears idle bit, cpu resumes
// [RL6] wake services interrupt, resumes after idle write
// [RL7] reset during idle runs normal reset sequence
// [RL8] watchdog timeout resets and ends idle
// [RL9] software may disable watchdog before idle
// [RL10] stop bit enters stop after writing instruction
// [RL11] stop halts cpu and precision oscillator
// [RL12] stop leaves low-power and external oscillators
// [RL13] only reset ends stop, vector zero
// [RL14] missing clock detector reset ends stop
// [RL15] software disables detector for long stops
// [RL16] software enables flash one-shot before low power
// [RL17] stop bit reads cleared after reset
`timescale 1ns/1ps
module ispm_top (
  input wire logic CLK_SYS, // 40 MHz system clock
  input wire logic ARST_N, // async reset, active low
  input wire logic [11:0] HADDR, // ahb address
  input wire logic [1:0] HTRANS, // ahb transfer type
  input wire logic HWRITE, // ahb write
  input wire logic [2:0] HSIZE, // ahb size
  input wire logic [31:0] HWDATA, // ahb write data
  input wire logic HSEL, // ahb slave select
  input wire logic HREADY, // ahb bus ready
  output logic [31:0] HRDATA, // ahb read data
  output logic HREADYOUT, // ahb slave ready
  output logic HRESP, // ahb response
  input wire logic INSN_DONE, // core: current instruction retired
  input wire logic IRQ_PENDING, // interrupt system: enabled interrupt asserted
  input wire logic WDT_RESET, // watchdog unit timeout reset request
  input wire logic MCD_RESET, // missing clock detector reset request
  input wire logic EXT_RESET, // external reset pin request
  output logic CPU_HALT, // cpu clock stop
  output logic HFOSC_HALT, // precision oscillator stop
  output logic CPU_RESET, // cpu reset sequence request
  output logic [15:0] RESET_VECTOR, // fetch address after reset
  output logic PERIPH_CLK_EN, // peripheral clock enable
  output logic [1:0] MODE // current power mode
);
  ispm_pkg::ispm_rst_src_t rst_raw;
  ispm_pkg::ispm_rst_src_t rst_sync;
  ispm_pkg::ispm_state_t state_q, state_d;
  ispm_pkg::ispm_ctrl_t ctrl_q, ctrl_d;
  logic [7:0] pwr_q, pwr_d;
  logic [31:0] wake_cfg_q, wake_cfg_d;
  logic [31:0] rdata_q, rdata_d;
  logic [11:0] addr_q, addr_d;
  logic wr_q, wr_d;
  logic [ispm_pkg::RST_CNT_W-1:0] rcnt_q, rcnt_d;
  logic any_reset;
  logic irq_wake;
  logic acc;

  assign rst_raw = '{wdt_reset: WDT_RESET, mcd_reset: MCD_RESET, ext_reset: EXT_RESET};

  ispm_sync #(.W(3)) u_sync (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .d(rst_raw),
    .q(rst_sync)
  );

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] r);
    addr_is = (a[11:2] == r[11:2]);
  endfunction

  // halt and reset controls for one power mode
  function automatic ispm_pkg::ispm_ctrl_t ctrl_of(input ispm_pkg::ispm_state_t s);
    ispm_pkg::ispm_ctrl_t c;
    // only clocks stop, so cpu registers and memory keep their contents
    c.cpu_halt = (s == ispm_pkg::ISPM_IDLE) || (s == ispm_pkg::ISPM_STOP); // RL2
    c.hfosc_halt = (s == ispm_pkg::ISPM_STOP); // RL11
    c.cpu_reset = (s == ispm_pkg::ISPM_RESET); // RL7 RL13
    return c;
  endfunction

  // idle watchdog and stop detector resets share one path into the reset sequence
  assign any_reset = rst_sync.wdt_reset | rst_sync.mcd_reset | rst_sync.ext_reset; // RL8 RL14
  // wake cfg bit 0 lets software mask interrupt wake for bring-up; 0 = wake allowed
  assign irq_wake = IRQ_PENDING & ~wake_cfg_q[ispm_pkg::BIT_WAKE_MASK];
  assign acc = HSEL & HREADY & HTRANS[1];

  always_comb
  begin
    state_d = state_q;
    pwr_d = pwr_q;
    rcnt_d = rcnt_q;
    case (state_q)
      ispm_pkg::ISPM_RUN:
      begin
        if (any_reset)
        begin
          state_d = ispm_pkg::ISPM_RESET;
        end
        else if (pwr_q[ispm_pkg::BIT_STOP] && INSN_DONE)
        begin
          state_d = ispm_pkg::ISPM_STOP; // RL10
        end
        else if (pwr_q[ispm_pkg::BIT_IDLE] && INSN_DONE)
        begin
          state_d = ispm_pkg::ISPM_IDLE; // RL1
        end
      end
      ispm_pkg::ISPM_IDLE:
      begin
        if (any_reset)
        begin
          state_d = ispm_pkg::ISPM_RESET; // RL4 RL7
        end
        else if (irq_wake)
        begin
          // core resumes at the next instruction and takes the interrupt first
          pwr_d[ispm_pkg::BIT_IDLE] = 1'b0; // RL5 RL6
          state_d = ispm_pkg::ISPM_RUN; // RL4
        end
      end
      ispm_pkg::ISPM_STOP:
      begin
        // interrupts are deliberately ignored here
        if (any_reset)
        begin
          state_d = ispm_pkg::ISPM_RESET; // RL13
        end
      end
      ispm_pkg::ISPM_RESET:
      begin
        pwr_d = ispm_pkg::RST_PWR_CTRL[7:0]; // RL17
        if (any_reset)
        begin
          rcnt_d = '0;
        end
        else if (rcnt_q == ispm_pkg::RST_CNT_W'(ispm_pkg::RST_HOLD_CYCLES - 1))
        begin
          state_d = ispm_pkg::ISPM_RUN; // RL7
          rcnt_d = '0;
        end
        else
        begin
          rcnt_d = rcnt_q + 1'b1;
        end
      end
      default:
      begin
        state_d = ispm_pkg::ISPM_RESET;
      end
    endcase
    // register write lands in the data phase; the core only writes while running
    if (wr_q && addr_is(addr_q, ispm_pkg::ADDR_PWR_CTRL) && state_q == ispm_pkg::ISPM_RUN)
    begin
      pwr_d = HWDATA[ispm_pkg::BIT_GP_HI:0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_q <= ispm_pkg::ISPM_RESET;
      pwr_q <= ispm_pkg::RST_PWR_CTRL[7:0];
      rcnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      pwr_q <= pwr_d;
      rcnt_q <= rcnt_d;
    end
  end

  always_comb
  begin
    addr_d = addr_q;
    wr_d = 1'b0;
    wake_cfg_d = wake_cfg_q;
    rdata_d = rdata_q;
    if (acc)
    begin
      addr_d = HADDR;
      wr_d = HWRITE;
    end
    if (wr_q && addr_is(addr_q, ispm_pkg::ADDR_WAKE_CFG))
    begin
      wake_cfg_d = {31'h0000_0000, HWDATA[ispm_pkg::BIT_WAKE_MASK]};
    end
    if (acc && !HWRITE)
    begin
      if (addr_is(HADDR, ispm_pkg::ADDR_PWR_CTRL))
      begin
        rdata_d = {24'h00_0000, pwr_q};
      end
      else if (addr_is(HADDR, ispm_pkg::ADDR_STATUS))
      begin
        rdata_d = {27'h000_0000, any_reset, irq_wake, CPU_HALT, state_q};
      end
      else if (addr_is(HADDR, ispm_pkg::ADDR_WAKE_CFG))
      begin
        rdata_d = wake_cfg_q;
      end
      else
      begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      addr_q <= 12'h000;
      wr_q <= 1'b0;
      wake_cfg_q <= ispm_pkg::RST_WAKE_CFG;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      addr_q <= addr_d;
      wr_q <= wr_d;
      wake_cfg_q <= wake_cfg_d;
      rdata_q <= rdata_d;
    end
  end

  // controls are registered beside the state so no decode glitch reaches a clock gate
  always_comb
  begin
    ctrl_d = ctrl_of(state_d);
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      // same controls as the reset state
      ctrl_q <= '{cpu_halt: 1'b0, hfosc_halt: 1'b0, cpu_reset: 1'b1};
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  assign CPU_HALT = ctrl_q.cpu_halt;
  assign HFOSC_HALT = ctrl_q.hfosc_halt; // RL11 RL12
  assign CPU_RESET = ctrl_q.cpu_reset;
  assign RESET_VECTOR = ispm_pkg::RESET_VECTOR; // RL13
  assign PERIPH_CLK_EN = 1'b1; // RL3
  assign MODE = state_q;
  assign HRDATA = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
endmodule

//--- tb/ispm_chk.sv
// checker: relations between power mode and the halt and reset outputs
// assumes the bind below on the top module, one clock domain
`timescale 1ns/1ps
module ispm_chk (
  input wire logic CLK_SYS, // clock
  input wire logic ARST_N, // reset, low
  input wire logic IRQ_PENDING, // wake request
  input wire logic HREADYOUT, // bus ready
  input wire logic HRESP, // bus response
  input wire logic CPU_HALT, // cpu stop
  input wire logic HFOSC_HALT, // osc stop
  input wire logic CPU_RESET, // reset sequence
  input wire logic [15:0] RESET_VECTOR, // fetch address
  input wire logic PERIPH_CLK_EN, // peripheral clock
  input wire logic [1:0] MODE // power mode
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  a_halt_in_low: assert property (CPU_HALT == (MODE inside {2'b01, 2'b11}))
    else $error("cpu halt does not follow mode");
  a_osc_in_stop: assert property (HFOSC_HALT == (MODE == 2'b11))
    else $error("oscillator halt does not follow mode");
  a_periph_runs: assert property (PERIPH_CLK_EN)
    else $error("peripheral clock gated");
  a_idle_wakes: assert property (MODE == 2'b01 && IRQ_PENDING |=> MODE != 2'b01)
    else $error("idle not left on interrupt");
  a_stop_holds: assert property (MODE == 2'b11 |=> MODE inside {2'b11, 2'b10})
    else $error("stop left without reset");
  a_reset_mode: assert property (CPU_RESET == (MODE == 2'b10))
    else $error("reset request does not follow mode");
  a_reset_len: assert property ($fell(CPU_RESET) |-> $past(CPU_RESET, 4))
    else $error("reset sequence too short");
  a_vector_zero: assert property ($fell(CPU_RESET) |-> RESET_VECTOR == 16'h0000)
    else $error("reset vector not zero");
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready okay");
  c_idle_wake: cover property (MODE == 2'b01 && IRQ_PENDING);
  c_stop_reset: cover property (MODE == 2'b11 ##1 MODE == 2'b10);
  c_reset_done: cover property ($fell(CPU_RESET));
endmodule
bind ispm_top ispm_chk u_chk (.CLK_SYS, .ARST_N, .IRQ_PENDING, .HREADYOUT, .HRESP,
  .CPU_HALT, .HFOSC_HALT, .CPU_RESET, .RESET_VECTOR, .PERIPH_CLK_EN, .MODE);

//--- tb/ispm_core_model.sv
// core model: retires one instruction per cycle while not halted
// assumes halt comes registered from the controller on the same clock
`timescale 1ns/1ps
module ispm_core_model (
  input wire logic clk, // system clock
  input wire logic arst_n, // reset, low
  input wire logic halt, // cpu clock stopped
  output logic insn_done, // instruction retired
  output logic [15:0] retired // retire count
);
  // a halted core retires nothing, so a frozen count shows held state
  assign insn_done = arst_n && !halt;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      retired <= 16'h0000;
    else if (insn_done)
      retired <= retired + 16'h0001;
  // flash one-shot taken as enabled by software before any low-power entry
endmodule

//--- tb/ispm_top_tb.sv
// testbench: bus access, idle and stop entry, wake and reset exits
// assumes a slave that may stretch its phases and the core model as instruction source
`timescale 1ns/1ps
module ispm_top_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic irq = 1'b0;
  logic wdt_on = 1'b1;
  logic mcd_on = 1'b1;
  ispm_pkg::ispm_rst_src_t src = '0;
  logic [31:0] hrdata, rd;
  logic rdy, hresp, done, halt, osc, cpu_rst, pclk;
  logic [15:0] rvec, retired, r0;
  logic [1:0] mode;
  int err_count = 0;
  int samples_checked = 0;
  ispm_top dut (.CLK_SYS(clk), .ARST_N(arst_n), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HSEL(1'b1), .HREADY(rdy),
    .HRDATA(hrdata), .HREADYOUT(rdy), .HRESP(hresp), .INSN_DONE(done), .IRQ_PENDING(irq),
    .WDT_RESET(src.wdt_reset & wdt_on), .MCD_RESET(src.mcd_reset & mcd_on),
    .EXT_RESET(src.ext_reset),
    .CPU_HALT(halt), .HFOSC_HALT(osc), .CPU_RESET(cpu_rst), .RESET_VECTOR(rvec),
    .PERIPH_CLK_EN(pclk), .MODE(mode));
  ispm_core_model core (.clk(clk), .arst_n(arst_n), .halt(halt), .insn_done(done),
    .retired(retired));
  initial
  forever #12.5 clk = ~clk;
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic bus(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrdata;
  endtask
  // mode is read as it stood before each edge, so drives after this stay on the edge
  task automatic wait_mode(logic [1:0] m);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (mode !== m && n < 60);
    chk("mode", 32'(m), 32'(mode));
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    chk("mode in reset", 32'h2, 32'(mode));
    arst_n <= 1'b1;
    wait_mode(2'b00);
    chk("vector", 32'h0, 32'(rvec));
    bus(1'b0, ispm_pkg::ADDR_PWR_CTRL, 32'h0);
    chk("pwr reset", ispm_pkg::RST_PWR_CTRL, rd);
    $display("test reset done");
    bus(1'b1, ispm_pkg::ADDR_WAKE_CFG, 32'h0000_0001);
    bus(1'b0, ispm_pkg::ADDR_WAKE_CFG, 32'h0);
    chk("wake cfg", 32'h0000_0001, rd);
    irq <= 1'b1;
    bus(1'b0, ispm_pkg::ADDR_STATUS, 32'h0);
    chk("status masked", 32'h0, rd);
    bus(1'b1, ispm_pkg::ADDR_WAKE_CFG, 32'h0);
    bus(1'b0, ispm_pkg::ADDR_STATUS, 32'h0);
    chk("status wake", 32'h0000_0008, rd);
    irq <= 1'b0;
    bus(1'b0, 12'h00c, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("bus response", 32'h0, 32'(hresp));
    $display("test registers done");
    wdt_on <= 1'b0;
    bus(1'b1, ispm_pkg::ADDR_PWR_CTRL, 32'h0000_00fd);
    wait_mode(2'b01);
    r0 = retired;
    chk("osc in idle", 32'h0, 32'(osc));
    chk("periph clock in idle", 32'h1, 32'(pclk));
    bus(1'b0, ispm_pkg::ADDR_PWR_CTRL, 32'h0);
    chk("pwr in idle", 32'h0000_00fd, rd);
    chk("frozen core", 32'(r0), 32'(retired));
    irq <= 1'b1;
    wait_mode(2'b00);
    @(posedge clk);
    irq <= 1'b0;
    bus(1'b0, ispm_pkg::ADDR_PWR_CTRL, 32'h0);
    chk("idle bit cleared", 32'h0000_00fc, rd);
    chk("core resumed", 32'h1, 32'(retired > r0));
    $display("test idle wake done");
    mcd_on <= 1'b0;
    bus(1'b1, ispm_pkg::ADDR_PWR_CTRL, 32'h0000_0002);
    wait_mode(2'b11);
    chk("osc in stop", 32'h1, 32'(osc));
    irq <= 1'b1;
    repeat (8) @(posedge clk);
    irq <= 1'b0;
    chk("stop holds", 32'h3, 32'(mode));
    $display("test stop done");
    wdt_on <= 1'b1;
    mcd_on <= 1'b1;
    // stop ends on the detector; idle then ends on each source in turn
    for (int i = 0; i < 4; i++)
    begin
      if (i > 0)
        bus(1'b1, ispm_pkg::ADDR_PWR_CTRL, 32'h0000_0001);
      if (i > 0)
        wait_mode(2'b01);
      @(posedge clk);
      // detector, then watchdog, detector and external pin in turn
      src <= ispm_pkg::ispm_rst_src_t'((i == 0) ? 3'b010 : 3'(3'b100 >> (i - 1)));
      repeat (3) @(posedge clk);
      src <= '0;
      wait_mode(2'b10);
      chk("cpu reset", 32'h1, 32'(cpu_rst));
      wait_mode(2'b00);
      chk("vector after reset", 32'h0, 32'(rvec));
      bus(1'b0, ispm_pkg::ADDR_PWR_CTRL, 32'h0);
      chk("mode bits cleared", 32'h0, rd & 32'h3);
    end
    $display("test reset exits done");
    bus(1'b1, ispm_pkg::ADDR_PWR_CTRL, 32'h0000_0001);
    wait_mode(2'b01);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("mode in async reset", 32'h2, 32'(mode));
    arst_n <= 1'b1;
    wait_mode(2'b00);
    bus(1'b0, ispm_pkg::ADDR_PWR_CTRL, 32'h0);
    chk("pwr after async reset", 32'h0, rd);
    $display("test async reset done");
    close_out();
  end
  initial
  begin
    #(25 * 20000);
    err_count++;
    close_out();
  end
endmodule
